// *** common/fbs_pkg.sv ***
package fbs_pkg;

	// Data path shape
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DATA_W = LANES * LANE_W;
	localparam int ADDR_W = 19;
	localparam int BURST_W = 2;

	// Lane masks
	localparam logic [LANES-1:0] LANES_ALL = 4'hF;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;

	// Burst counter
	localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;

	// Burst order strap levels
	localparam logic ORDER_LINEAR = 1'b0;
	localparam logic ORDER_INTERLEAVED = 1'b1;

	// Clock and sleep timing, the sleep figures are in clock periods
	localparam int CLK_PERIOD_NS = 20;
	localparam int SLEEP_ENTRY_TCYC = 2;
	localparam int SLEEP_RECOVERY_TCYC = 2;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_TCYC * CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_CYC = SLEEP_RECOVERY_TCYC * CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SLP_CNT_W = 2;
	localparam logic [SLP_CNT_W-1:0] SLP_CNT_ONE = 2'h1;
	localparam logic [SLP_CNT_W-1:0] SLP_ENTRY_LAST = SLP_CNT_W'(SLEEP_ENTRY_CYC - 1);
	localparam logic [SLP_CNT_W-1:0] SLP_EXIT_LAST = SLP_CNT_W'(SLEEP_RECOVERY_CYC - 1);

	// Sleep sequencing states
	typedef enum logic [1:0] {
		SLP_AWAKE,
		SLP_ENTER,
		SLP_ASLEEP,
		SLP_EXIT
	} fbs_sleep_e;

	// Low address bits of a given beat in the selected burst order
	function automatic logic [BURST_W-1:0] fbsBurstLow(input logic order,
		input logic [BURST_W-1:0] start, input logic [BURST_W-1:0] beat);
		if (order == ORDER_INTERLEAVED) begin
			fbsBurstLow = start ^ beat;
		end else begin
			fbsBurstLow = start + beat;
		end
	endfunction : fbsBurstLow

endpackage : fbs_pkg

// *** testbench/fbs_burst_sram_test.sv ***
`timescale 1ns/10ps
module fbs_burst_sram_test;
	import fbs_pkg::*;
	// Cycle kinds {selected, procN, ctrlN, advN} and write inputs {allN, bweN, lanesN}
	localparam logic [3:0] DESEL = 4'h5, IDLE = 4'h7, BURST_ADVANCE_N = 4'h6, CST = 4'hD, PST = 4'hB;
	localparam logic [3:0] BOTH = 4'h9;
	localparam logic [5:0] WNO = 6'h3F, WGW = 6'h1F, WBY = 6'h2A, WEN = 6'h2F, WSEL = 6'h30;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic [5:0] addr;
	logic chipSel1N, chipSel2, chipSel3N, processorAddrStrobeN, controllerAddrStrobeN;
	logic burstAdvanceN, burstOrder, allLanesWriteN, byteLaneWriteEnableN, outputEnableN;
	logic sleepRequest, dqOe, sleeping;
	logic [3:0] byteLaneSelectN;
	logic [DATA_W-1:0] dqIn, dqOut;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Small address space keeps the array short
	fbs_burst_sram #(.ADDR_W(6)) fbs_burst_sram_inst (.core_clk, .resetn, .clkEn(1'h1),
		.addr, .chipSel1N, .chipSel2, .chipSel3N, .processorAddrStrobeN,
		.controllerAddrStrobeN, .burstAdvanceN, .burstOrder, .allLanesWriteN,
		.byteLaneWriteEnableN, .byteLaneSelectN, .outputEnableN, .sleepRequest, .dqIn,
		.dqOut, .dqOe, .sleeping);
	fbs_host_model fbs_host_model_inst (.core_clk, .dqOut, .dqOe, .addr, .chipSel1N,
		.chipSel2, .chipSel3N, .processorAddrStrobeN, .controllerAddrStrobeN, .burstAdvanceN,
		.burstOrder, .allLanesWriteN, .byteLaneWriteEnableN, .byteLaneSelectN, .outputEnableN,
		.sleepRequest, .dqIn);
	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard, the run needs about 60 cycles
	initial forever #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	task automatic bus(input logic [3:0] c, input logic [5:0] w, input logic [5:0] a,
		input logic [DATA_W-1:0] d);
		fbs_host_model_inst.op(c, w, a, d);
	endtask : bus
	////////////////////////////////////////////////////////////////////////////////
	// Controller write with enable held low, then a read out of deselect
	task automatic s_write_read;
		fbs_host_model_inst.defyOe = 1'h1;
		bus(CST, WGW, 6'h05, 32'h11223344);
		check("write float", 32'(dqOe), 32'h0);
		fbs_host_model_inst.defyOe = 1'h0;
		bus(DESEL, WNO, 6'h00, 32'h0);
		bus(PST, WNO, 6'h05, 32'h0);
		bus(IDLE, WNO, 6'h00, 32'h0);
		check("read data", dqOut, 32'h11223344);
		check("first read masked", 32'(dqOe), 32'h0);
		bus(IDLE, WNO, 6'h00, 32'h0);
		check("read drive", 32'(dqOe), 32'h1);
	endtask : s_write_read
	// Both strobes with writes ignored, then lane writes and non-writes
	task automatic s_lanes;
		fbs_host_model_inst.defyOe = 1'h1;
		bus(CST, WGW, 6'h08, 32'h01020304);
		bus(BOTH, WGW, 6'h08, 32'hFFFFFFFF);
		bus(IDLE, WBY, 6'h00, 32'hAABBCCDD);
		check("proc start read", dqOut, 32'h01020304);
		check("lane write float", 32'(dqOe), 32'h0);
		bus(IDLE, WEN, 6'h00, 32'h55555555);
		bus(IDLE, WSEL, 6'h00, 32'h66666666);
		fbs_host_model_inst.defyOe = 1'h0;
		bus(CST, WNO, 6'h08, 32'h0);
		bus(IDLE, WNO, 6'h00, 32'h0);
		check("lane merge", dqOut, 32'h01BB03DD);
	endtask : s_lanes
	// Both orders, two start points each, five beats to see the wrap
	task automatic s_burst;
		logic ord;
		logic [1:0] s;
		logic [1:0] e;
		for (int k = 0; k < 4; k++) begin
			bus(CST, WGW, 6'h10 + 6'(k), 32'hB0000000 + 32'(k));
		end
		for (int m = 0; m < 4; m++) begin
			ord = m[1];
			s = m[0] ? 2'h3 : (ord ? 2'h2 : 2'h1);
			fbs_host_model_inst.order = ord;
			bus(CST, WNO, {4'h4, s}, 32'h0);
			for (int b = 0; b < 5; b++) begin
				bus(BURST_ADVANCE_N, WNO, 6'h00, 32'h0);
				e = ord ? s ^ 2'(b) : s + 2'(b);
				check("burst beat", dqOut, 32'hB0000000 + 32'(e));
			end
		end
	endtask : s_burst
	// Sleep entry, a refused write while asleep, recovery and data kept
	task automatic s_sleep;
		bus(DESEL, WNO, 6'h00, 32'h0);
		fbs_host_model_inst.doze = 1'h1;
		bus(IDLE, WNO, 6'h00, 32'h0);
		bus(IDLE, WNO, 6'h00, 32'h0);
		check("entering", 32'(sleeping), 32'h0);
		bus(CST, WGW, 6'h05, 32'h0BADF00D);
		check("asleep", 32'(sleeping), 32'h1);
		fbs_host_model_inst.doze = 1'h0;
		bus(IDLE, WNO, 6'h00, 32'h0);
		// Low level not yet sampled, so the device must still be asleep
		check("leaving", 32'(sleeping), 32'h1);
		bus(IDLE, WNO, 6'h00, 32'h0);
		bus(IDLE, WNO, 6'h00, 32'h0);
		check("awake", 32'(sleeping), 32'h0);
		bus(CST, WNO, 6'h05, 32'h0);
		bus(IDLE, WNO, 6'h00, 32'h0);
		check("kept data", dqOut, 32'h11223344);
	endtask : s_sleep
	// Reset for 12 cycles, then the scenarios
	initial begin
		repeat (12) @(posedge core_clk);
		#1;
		resetn = 1'h1;
		s_write_read();
		s_lanes();
		s_burst();
		s_sleep();
		wrap_up();
	end
endmodule : fbs_burst_sram_test

// *** testbench/fbs_host_model.sv ***
`timescale 1ns/10ps
module fbs_host_model (
	// Clock and device answer
	input wire logic core_clk,
	input wire logic [fbs_pkg::DATA_W-1:0] dqOut,
	input wire logic dqOe,
	// Address, selects and strobes
	output logic [5:0] addr,
	output logic chipSel1N,
	output logic chipSel2,
	output logic chipSel3N,
	output logic processorAddrStrobeN,
	output logic controllerAddrStrobeN,
	output logic burstAdvanceN,
	output logic burstOrder,
	// Write control, enable, sleep and data
	output logic allLanesWriteN,
	output logic byteLaneWriteEnableN,
	output logic [3:0] byteLaneSelectN,
	output logic outputEnableN,
	output logic sleepRequest,
	output logic [fbs_pkg::DATA_W-1:0] dqIn
);
	import fbs_pkg::*;
	logic order, doze, defyOe, drv;
	logic [DATA_W-1:0] wrData;
	logic [DATA_W-1:0] lastReg = '0;
	////////////////////////////////////////////////////////////////////////////////
	// Write inputs away from idle mean the host owns the data lines
	assign drv = {allLanesWriteN, byteLaneWriteEnableN, byteLaneSelectN} != 6'h3F;
	// Lines driven by neither side show the inverse of the last value, so stale data never matches
	assign dqIn = drv ? wrData : (dqOe ? dqOut : ~lastReg);
	always @(posedge core_clk) lastReg <= dqIn;
	// Idle levels from time zero
	initial begin
		{chipSel1N, chipSel2, chipSel3N} = 3'h5;
		{processorAddrStrobeN, controllerAddrStrobeN, burstAdvanceN} = 3'h7;
		{allLanesWriteN, byteLaneWriteEnableN, byteLaneSelectN} = 6'h3F;
		{addr, wrData} = '0;
		outputEnableN = 1'h0;
		// Interleaved strap by default, awake, enable obeyed
		{burstOrder, sleepRequest, order, doze, defyOe} = 5'h14;
	end
	// one bus cycle, pins change just after the edge
	task automatic op(input logic [3:0] ctl, input logic [5:0] wr, input logic [5:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		#1;
		{chipSel1N, chipSel2, chipSel3N} = ctl[3] ? 3'h2 : 3'h5;
		{processorAddrStrobeN, controllerAddrStrobeN, burstAdvanceN} = ctl[2:0];
		{allLanesWriteN, byteLaneWriteEnableN, byteLaneSelectN} = wr;
		// enable released whenever write data is driven, unless defyOe is set
		outputEnableN = (wr != 6'h3F) && !defyOe;
		addr = a;
		wrData = d;
		burstOrder = order;
		// sleep level chosen by the caller
		sleepRequest = doze;
		#1;
	endtask : op
endmodule : fbs_host_model

// *** verilog/fbs_burst_sram.sv ***
`timescale 1ns/10ps
module fbs_burst_sram #(
	parameter int ADDR_W = fbs_pkg::ADDR_W
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Address and selects
	input wire logic [ADDR_W-1:0] addr,
	input wire logic chipSel1N,
	input wire logic chipSel2,
	input wire logic chipSel3N,
	// Burst control
	input wire logic processorAddrStrobeN,
	input wire logic controllerAddrStrobeN,
	input wire logic burstAdvanceN,
	input wire logic burstOrder,
	// Write control
	input wire logic allLanesWriteN,
	input wire logic byteLaneWriteEnableN,
	input wire logic [fbs_pkg::LANES-1:0] byteLaneSelectN,
	// Output enable and sleep
	input wire logic outputEnableN,
	input wire logic sleepRequest,
	// Data pins
	input wire logic [fbs_pkg::DATA_W-1:0] dqIn,
	output logic [fbs_pkg::DATA_W-1:0] dqOut,
	output logic dqOe,
	output logic sleeping
);
	import fbs_pkg::*;

	logic selected;
	logic writeReq;
	logic [LANES-1:0] laneMask;
	logic procStart;
	logic ctrlStart;
	logic startAcc;
	logic startDesel;
	logic contAcc;
	logic awake;
	logic wrEn;
	logic rdEn;
	logic writeNow;
	logic [BURST_W-1:0] beatNext;
	logic [ADDR_W-1:0] accAddr;
	logic [ADDR_W-1:0] addrReg;
	logic [BURST_W-1:0] burstStartReg;
	logic [BURST_W-1:0] burstCntReg;
	logic activeReg;
	logic readingReg;
	logic maskReg;
	logic deselReg;
	fbs_sleep_e slpReg;
	logic [SLP_CNT_W-1:0] slpCntReg;

	////////////////////////////////////////////////////////////////////////////
	// Input decode
	// select decode
	assign selected = !chipSel1N && chipSel2 && !chipSel3N;
	assign writeReq = !allLanesWriteN || (!byteLaneWriteEnableN && byteLaneSelectN != LANES_ALL);

	// Lane mask; global write overrides the byte controls
	always_comb begin
		if (!allLanesWriteN) begin
			laneMask = LANES_ALL;
		end else if (!byteLaneWriteEnableN) begin
			laneMask = ~byteLaneSelectN;
		end else begin
			laneMask = LANES_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cycle classification; nothing starts unless fully awake
	assign awake = (slpReg == SLP_AWAKE);
	assign procStart = awake && !processorAddrStrobeN && !chipSel1N;
	assign ctrlStart = awake && !procStart && !controllerAddrStrobeN;
	assign startAcc = (procStart || ctrlStart) && selected;
	assign startDesel = (procStart || ctrlStart) && !selected;
	assign contAcc = awake && !procStart && !ctrlStart && activeReg;

	assign wrEn = awake && !procStart && writeReq && (startAcc || contAcc);
	assign rdEn = (startAcc || contAcc) && !wrEn;

	assign beatNext = burstAdvanceN ? burstCntReg : burstCntReg + BEAT_STEP;

	// Access address: presented on a start, otherwise burst sequence
	always_comb begin
		if (startAcc) begin
			accAddr = addr;
		end else begin
			accAddr = {addrReg[ADDR_W-1:BURST_W],
				fbsBurstLow(burstOrder, burstStartReg, beatNext)};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address register and burst counter
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			addrReg <= '0;
			burstStartReg <= BEAT_FIRST;
			burstCntReg <= BEAT_FIRST;
		end else if (clkEn) begin
			if (startAcc) begin
				addrReg <= addr;
				burstStartReg <= addr[BURST_W-1:0];
				burstCntReg <= BEAT_FIRST;
			end else if (contAcc) begin
				burstCntReg <= beatNext;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Access tracking; sleep drops whatever was in flight
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			activeReg <= 1'b0;
			deselReg <= 1'b1;
		end else if (clkEn) begin
			if (!awake || startDesel) begin
				activeReg <= 1'b0;
				deselReg <= 1'b1;
			end else if (startAcc) begin
				activeReg <= 1'b1;
				deselReg <= 1'b0;
			end
		end
	end

	// Drive qualifier for the cycle after each edge
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			readingReg <= 1'b0;
			maskReg <= 1'b0;
		end else if (clkEn) begin
			readingReg <= rdEn;
			maskReg <= startAcc && deselReg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sleep sequencing; entry and exit each need consecutive cycles of the level
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			slpReg <= SLP_AWAKE;
			slpCntReg <= '0;
		end else if (clkEn) begin
			case (slpReg)
				SLP_AWAKE: begin
					if (sleepRequest) begin
						slpReg <= (SLP_ENTRY_LAST == '0) ? SLP_ASLEEP : SLP_ENTER;
						slpCntReg <= SLP_CNT_ONE;
					end
				end
				SLP_ENTER: begin
					if (!sleepRequest) begin
						slpReg <= SLP_AWAKE;
					end else if (slpCntReg >= SLP_ENTRY_LAST) begin
						slpReg <= SLP_ASLEEP;
					end else begin
						slpCntReg <= slpCntReg + SLP_CNT_ONE;
					end
				end
				SLP_ASLEEP: begin
					if (!sleepRequest) begin
						slpReg <= (SLP_EXIT_LAST == '0) ? SLP_AWAKE : SLP_EXIT;
						slpCntReg <= SLP_CNT_ONE;
					end
				end
				SLP_EXIT: begin
					if (sleepRequest) begin
						slpReg <= SLP_ASLEEP;
					end else if (slpCntReg >= SLP_EXIT_LAST) begin
						slpReg <= SLP_AWAKE;
					end else begin
						slpCntReg <= slpCntReg + SLP_CNT_ONE;
					end
				end
				default: begin
					slpReg <= SLP_AWAKE;
				end
			endcase
		end
	end

	assign sleeping = (slpReg == SLP_ASLEEP);

	////////////////////////////////////////////////////////////////////////////
	// Storage; the array is never reset or cleared, so sleep loses nothing
	// contents kept
	fbs_core_array #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LANE_W)
	) u_array (
		.core_clk(core_clk),
		.clkEn(clkEn),
		.accAddr(accAddr),
		.rdEn(rdEn),
		.wrEn(wrEn),
		.wrLanes(laneMask),
		.wrData(dqIn),
		.rdData(dqOut)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pin drive; output enable is not sampled so it acts within the cycle
	// A write seen now floats the pins at once, since the host drives them already
	assign writeNow = writeReq && !procStart && (ctrlStart || activeReg);
	assign dqOe = readingReg && !maskReg && !outputEnableN && !writeNow && awake;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_global_lanes;
		(wrEn && !allLanesWriteN) |-> (laneMask == LANES_ALL);
	endproperty
	a_global_lanes: assert property (p_global_lanes) else $error("global write missed lanes");

	property p_byte_lanes;
		(wrEn && allLanesWriteN) |-> (!byteLaneWriteEnableN && laneMask == ~byteLaneSelectN);
	endproperty
	a_byte_lanes: assert property (p_byte_lanes) else $error("byte write lanes wrong");

	property p_proc_read;
		(!processorAddrStrobeN && !chipSel1N) |-> !wrEn;
	endproperty
	a_proc_read: assert property (p_proc_read) else $error("write on processor start");

	property p_ctrl_write;
		(awake && processorAddrStrobeN && !controllerAddrStrobeN && selected && writeReq)
			|-> (wrEn && accAddr == addr);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("controller write not taken");

	property p_capture;
		(clkEn && startAcc) |=> (addrReg == $past(addr) && burstCntReg == BEAT_FIRST);
	endproperty
	a_capture: assert property (p_capture) else $error("address not captured");

	property p_advance;
		(clkEn && contAcc && !burstAdvanceN) |=> (burstCntReg == $past(burstCntReg) + BEAT_STEP);
	endproperty
	a_advance: assert property (p_advance) else $error("burst did not step");

	property p_order;
		(contAcc && burstOrder == ORDER_INTERLEAVED)
			|-> (accAddr[BURST_W-1:0] == (burstStartReg ^ beatNext));
	endproperty
	a_order: assert property (p_order) else $error("interleaved order wrong");

	property p_write_float;
		writeNow |-> !dqOe;
	endproperty
	a_write_float: assert property (p_write_float) else $error("pins driven during write");

	property p_first_mask;
		(clkEn && startAcc && deselReg) |=> !dqOe;
	endproperty
	a_first_mask: assert property (p_first_mask) else $error("first read not masked");

	property p_read_drive;
		(clkEn && startAcc && !deselReg && !wrEn) ##1 (awake && !outputEnableN && !writeNow)
			|-> dqOe;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read data not driven");

	property p_sleep_entry;
		(clkEn && awake && sleepRequest) ##1 (clkEn && sleepRequest) |=> sleeping;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry not two cycles");

	property p_sleep_quiet;
		!awake |-> (!wrEn && !dqOe);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("access while sleeping");

	c_ctrl_write: cover property (clkEn && ctrlStart && wrEn);
	c_proc_then_write: cover property (clkEn && procStart && selected ##1 clkEn && wrEn);
	c_burst_four: cover property ((clkEn && contAcc && !burstAdvanceN) [*3]);
	c_sleep_cycle: cover property (sleeping ##[1:20] awake);

endmodule : fbs_burst_sram

// *** verilog/fbs_core_array.sv ***
`timescale 1ns/10ps
module fbs_core_array #(
	parameter int ADDR_W = fbs_pkg::ADDR_W,
	parameter int LANES = fbs_pkg::LANES,
	parameter int LANE_W = fbs_pkg::LANE_W
) (
	// Clocking
	input wire logic core_clk,
	input wire logic clkEn,
	// Access port
	input wire logic [ADDR_W-1:0] accAddr,
	input wire logic rdEn,
	input wire logic wrEn,
	input wire logic [LANES-1:0] wrLanes,
	input wire logic [LANES*LANE_W-1:0] wrData,
	output logic [LANES*LANE_W-1:0] rdData
);
	import fbs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// One array per lane so partial writes leave other lanes alone,
	// and every lane array keeps a single writing process
	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++) begin : g_lane
			logic [LANE_W-1:0] laneWords [0:(2**ADDR_W)-1];
			logic [LANE_W-1:0] laneRdReg;
			always_ff @(posedge core_clk) begin
				if (clkEn && wrEn && wrLanes[lane]) begin
					laneWords[accAddr] <= wrData[lane*LANE_W +: LANE_W];
				end
			end
			// Read data is registered on the address edge, so it is valid in the cycle after that edge
			always_ff @(posedge core_clk) begin
				if (clkEn && rdEn) begin
					laneRdReg <= laneWords[accAddr];
				end
			end
			assign rdData[lane*LANE_W +: LANE_W] = laneRdReg;
		end
	endgenerate

endmodule : fbs_core_array
